//--- rtl/xfer_ctrl.sv
// register set and transfer engine of the eight-channel transfer controller
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - eight identical channels 0..7, each with its full register group
// - two status registers are shared by all channels
// - control bit 15 enables the channel; resets to zero
// - control bit 14 selects byte transfers, else word transfers
// - bits 5-4 pick increment, no increment, peripheral indirect, reserved
// - writing the force bit does one transfer; else request line starts transfers
// - software cannot clear force; hardware clears it after the forced transfer
// - bits 6-0 choose one of 128 request lines
// - sixteen-bit primary buffer start address, reset zero
// - sixteen-bit secondary buffer start address, reset zero
// - sixteen-bit peripheral address used for the peripheral side
// - ten-bit count, upper bits read zero; block is count plus one
// - status 0 bits 15-8 peripheral collision flags, clearable, reset zero
// - status 0 bits 7-0 buffer collision flags, clearable, reset zero
// - status 1 bits 11-8 last channel, 1111 after reset
// - status 1 bits 7-0 show which buffer each channel uses
// - read-only register holds most recent buffer address, reset zero
// - direction bit selects buffer-to-peripheral or peripheral-to-buffer
// - interrupt at block end, or at half block when selected
// - one-shot stops after one block (two in ping-pong); continuous reloads start address
// - ping-pong alternates primary and secondary buffers per block
module xfer_ctrl
(
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic [6:0]   reg_addr,
    input  wire logic [15:0]  reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output logic [15:0]       reg_rdata,
    input  wire logic [127:0] trigger_source_line,
    input  wire logic [15:0]  periph_offset,
    input  wire logic [15:0]  ram_rdata,
    input  wire logic [15:0]  per_rdata,
    input  wire logic         cpu_ram_we,
    input  wire logic [15:0]  cpu_ram_addr,
    input  wire logic         cpu_per_we,
    input  wire logic [15:0]  cpu_per_addr,
    output logic [15:0]       ram_addr,
    output logic [15:0]       ram_wdata,
    output logic              ram_re,
    output logic              ram_we,
    output logic              ram_byte,
    output logic [15:0]       per_addr,
    output logic [15:0]       per_wdata,
    output logic              per_re,
    output logic              per_we,
    output logic              per_byte,
    output logic [7:0]        irq
);
    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [15:0] ctl_reg [8];
    logic        force_reg [8];
    logic [6:0]  sel_reg [8];
    logic [15:0] sta_reg [8];
    logic [15:0] stb_reg [8];
    logic [15:0] pad_reg [8];
    logic [9:0]  cnt_reg [8];
    logic [7:0]  pcol_reg;
    logic [7:0]  rcol_reg;
    logic [3:0]  last_ch_reg;
    logic [15:0] last_ram_reg;
    logic [15:0] rdata_reg;
    logic [7:0]  irq_reg;
    xfer_pkg::xfer_state_t state_reg;
    logic [2:0]  cur_reg;
    logic [7:0]  trig;
    logic [7:0]  grant;
    logic [7:0]  pend;
    logic [7:0]  tog;
    logic [7:0]  irq_evt;
    logic [7:0]  stop_evt;
    logic [15:0] ch_ram [8];
    logic [2:0]  pick;
    logic        any_pend;
    // decoded write strobes
    logic        wr_ch;
    logic [2:0]  wr_n;
    logic [2:0]  wr_r;

    assign wr_n  = reg_addr[5:3];
    assign wr_r  = reg_addr[2:0];
    assign wr_ch = reg_wr && !reg_addr[6];
    // byte transfers keep only the low lane
    function automatic logic [15:0] size_data(input logic is_byte, input logic [15:0] d);
        size_data = is_byte ? {8'h00, d[7:0]} : d;
    endfunction

    // ----------------------------------------------------------------
    // channel trackers
    // ----------------------------------------------------------------
    for (genvar c = 0; c < 8; c++)
    begin : g_ch
        // the force write is itself the request; the line is ignored while force waits
        assign trig[c]  = (wr_ch && wr_n == 3'(c) && wr_r == xfer_pkg::OFS_REQ && reg_wdata[xfer_pkg::B_FORCE])
                          || (!force_reg[c] && trigger_source_line[sel_reg[c]]);
        assign grant[c] = (state_reg == xfer_pkg::ST_FETCH) && (cur_reg == 3'(c));
        chan_track u_track
        (
            .clock         (clock),
            .nrst          (nrst),
            .enable        (ctl_reg[c][xfer_pkg::B_ON]),
            .mode          (ctl_reg[c][xfer_pkg::B_MD_LO +: 2]),
            .addressing_sel         (ctl_reg[c][xfer_pkg::B_AM_LO +: 2]),
            .byte_sel      (ctl_reg[c][xfer_pkg::B_SIZE]),
            .half_sel      (ctl_reg[c][xfer_pkg::B_HALF]),
            .sta           (sta_reg[c]),
            .stb           (stb_reg[c]),
            .cnt           (cnt_reg[c]),
            .periph_offset (periph_offset),
            .trig          (trig[c]),
            .grant         (grant[c]),
            .pending       (pend[c]),
            .toggle        (tog[c]),
            .ram_addr      (ch_ram[c]),
            .irq_evt       (irq_evt[c]),
            .stop_evt      (stop_evt[c])
        );
    end
    // fixed priority: lowest channel number first
    always_comb
    begin
        pick     = 3'h0;
        any_pend = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            if (pend[i])
            begin
                pick     = 3'(i);
                any_pend = 1'b1;
            end
        end
    end
    // ----------------------------------------------------------------
    // channel registers
    // ----------------------------------------------------------------
    // control: one-shot end clears the enable, a same-cycle write wins
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (!nrst)
                ctl_reg[i] <= xfer_pkg::RST_WORD;
            else if (wr_ch && wr_n == 3'(i) && wr_r == xfer_pkg::OFS_CTL)
                ctl_reg[i] <= reg_wdata & xfer_pkg::CTL_MASK;
            else if (stop_evt[i])
                ctl_reg[i][xfer_pkg::B_ON] <= 1'b0;
        end
    end

    // force is set only by software, cleared only by the finished transfer
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (!nrst)
                force_reg[i] <= 1'b0;
            else if (wr_ch && wr_n == 3'(i) && wr_r == xfer_pkg::OFS_REQ
                     && reg_wdata[xfer_pkg::B_FORCE])
                force_reg[i] <= 1'b1;
            else if (grant[i])
                force_reg[i] <= 1'b0;
        end
    end

    // plain read/write words; unused upper count bits are never stored
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (!nrst)
            begin
                sel_reg[i] <= 7'h00;
                sta_reg[i] <= xfer_pkg::RST_WORD;
                stb_reg[i] <= xfer_pkg::RST_WORD;
                pad_reg[i] <= xfer_pkg::RST_WORD;
                cnt_reg[i] <= 10'h000;
            end
            else if (wr_ch && wr_n == 3'(i))
            begin
                if (wr_r == xfer_pkg::OFS_REQ)
                    sel_reg[i] <= reg_wdata[6:0];
                if (wr_r == xfer_pkg::OFS_STA)
                    sta_reg[i] <= reg_wdata;
                if (wr_r == xfer_pkg::OFS_STB)
                    stb_reg[i] <= reg_wdata;
                // writes while enabled are the caller's hazard
                if (wr_r == xfer_pkg::OFS_PAD)
                    pad_reg[i] <= reg_wdata;
                if (wr_r == xfer_pkg::OFS_CNT)
                    cnt_reg[i] <= reg_wdata[9:0];
            end
        end
    end
    // ----------------------------------------------------------------
    // transfer engine
    // ----------------------------------------------------------------
    // read source, wait a cycle for data, then write destination
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            state_reg <= xfer_pkg::ST_IDLE;
            cur_reg   <= 3'h0;
        end
        else
        begin
            unique case (state_reg)
                xfer_pkg::ST_IDLE:
                begin
                    if (any_pend)
                    begin
                        cur_reg   <= pick;
                        state_reg <= xfer_pkg::ST_READ;
                    end
                end
                xfer_pkg::ST_READ:  state_reg <= xfer_pkg::ST_FETCH;
                xfer_pkg::ST_FETCH: state_reg <= xfer_pkg::ST_WRITE;
                xfer_pkg::ST_WRITE: state_reg <= xfer_pkg::ST_IDLE;
            endcase
        end
    end

    // bus strobes are registered so they reach the ports glitch free
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            ram_addr  <= xfer_pkg::RST_WORD;
            ram_wdata <= xfer_pkg::RST_WORD;
            ram_re    <= 1'b0;
            ram_we    <= 1'b0;
            ram_byte  <= 1'b0;
            per_addr  <= xfer_pkg::RST_WORD;
            per_wdata <= xfer_pkg::RST_WORD;
            per_re    <= 1'b0;
            per_we    <= 1'b0;
            per_byte  <= 1'b0;
        end
        else
        begin
            ram_re <= 1'b0;
            ram_we <= 1'b0;
            per_re <= 1'b0;
            per_we <= 1'b0;
            if (state_reg == xfer_pkg::ST_IDLE && any_pend)
            begin
                ram_addr <= ch_ram[pick];
                per_addr <= pad_reg[pick];
                ram_byte <= ctl_reg[pick][xfer_pkg::B_SIZE];
                per_byte <= ctl_reg[pick][xfer_pkg::B_SIZE];
                // direction set: buffer to peripheral, else peripheral to buffer
                ram_re   <= ctl_reg[pick][xfer_pkg::B_DIR];
                per_re   <= !ctl_reg[pick][xfer_pkg::B_DIR];
            end
            if (state_reg == xfer_pkg::ST_FETCH)
            begin
                if (ctl_reg[cur_reg][xfer_pkg::B_DIR])
                begin
                    per_we    <= 1'b1;
                    per_wdata <= size_data(ctl_reg[cur_reg][xfer_pkg::B_SIZE], ram_rdata);
                end
                else
                begin
                    ram_we    <= 1'b1;
                    ram_wdata <= size_data(ctl_reg[cur_reg][xfer_pkg::B_SIZE], per_rdata);
                    // dummy zero write keeps the peripheral clocking in data
                    if (ctl_reg[cur_reg][xfer_pkg::B_DUMMY_WRITE_EN])
                    begin
                        per_we    <= 1'b1;
                        per_wdata <= 16'h0000;
                    end
                end
            end
        end
    end
    // ----------------------------------------------------------------
    // shared status
    // ----------------------------------------------------------------
    // collision with a cpu write to the same location; set wins over clear
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (!nrst)
            begin
                pcol_reg[i] <= 1'b0;
                rcol_reg[i] <= 1'b0;
            end
            else
            begin
                if (state_reg == xfer_pkg::ST_WRITE && cur_reg == 3'(i)
                    && per_we && cpu_per_we && cpu_per_addr == per_addr)
                    pcol_reg[i] <= 1'b1;
                else if (reg_wr && reg_addr == xfer_pkg::OFS_CS0 && reg_wdata[8 + i])
                    pcol_reg[i] <= 1'b0;
                if (state_reg == xfer_pkg::ST_WRITE && cur_reg == 3'(i)
                    && ram_we && cpu_ram_we && cpu_ram_addr == ram_addr)
                    rcol_reg[i] <= 1'b1;
                else if (reg_wr && reg_addr == xfer_pkg::OFS_CS0 && reg_wdata[i])
                    rcol_reg[i] <= 1'b0;
            end
        end
    end

    // last channel and last buffer address follow each completed transfer
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            last_ch_reg  <= xfer_pkg::RST_LAST;
            last_ram_reg <= xfer_pkg::RST_WORD;
        end
        else if (state_reg == xfer_pkg::ST_WRITE)
        begin
            last_ch_reg  <= {1'b0, cur_reg};
            last_ram_reg <= ram_addr;
        end
    end

    // one-cycle interrupt pulse per channel
    always_ff @(posedge clock)
    begin
        if (!nrst)
            irq_reg <= 8'h00;
        else
            irq_reg <= irq_evt;
    end
    assign irq = irq_reg;
    // ----------------------------------------------------------------
    // register read port
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!nrst)
            rdata_reg <= xfer_pkg::RST_WORD;
        else if (reg_rd)
        begin
            rdata_reg <= 16'h0000;
            if (!reg_addr[6])
            begin
                unique case (wr_r)
                    xfer_pkg::OFS_CTL: rdata_reg <= ctl_reg[wr_n];
                    xfer_pkg::OFS_REQ: rdata_reg <= {force_reg[wr_n], 8'h00, sel_reg[wr_n]};
                    xfer_pkg::OFS_STA: rdata_reg <= sta_reg[wr_n];
                    xfer_pkg::OFS_STB: rdata_reg <= stb_reg[wr_n];
                    xfer_pkg::OFS_PAD: rdata_reg <= pad_reg[wr_n];
                    xfer_pkg::OFS_CNT: rdata_reg <= {6'h00, cnt_reg[wr_n]};
                    default:           rdata_reg <= 16'h0000;
                endcase
            end
            else if (reg_addr == xfer_pkg::OFS_CS0)
                rdata_reg <= {pcol_reg, rcol_reg};
            else if (reg_addr == xfer_pkg::OFS_CS1)
                rdata_reg <= {4'h0, last_ch_reg, tog};
            else if (reg_addr == xfer_pkg::OFS_LAST)
                rdata_reg <= last_ram_reg;
        end
    end
    assign reg_rdata = rdata_reg;
endmodule // xfer_ctrl

//--- shared/xfer_pkg.sv
// shared constants and types of the eight-channel transfer controller
package xfer_pkg;
    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int unsigned NUM_CH   = 8;
    localparam int unsigned CNT_W    = 10;
    localparam int unsigned ADDR_W   = 7;
    // ----------------------------------------------------------------
    // register offsets: channel register index, channel number above
    // ----------------------------------------------------------------
    localparam logic [2:0] OFS_CTL  = 3'h0;
    localparam logic [2:0] OFS_REQ  = 3'h1;
    localparam logic [2:0] OFS_STA  = 3'h2;
    localparam logic [2:0] OFS_STB  = 3'h3;
    localparam logic [2:0] OFS_PAD  = 3'h4;
    localparam logic [2:0] OFS_CNT  = 3'h5;
    localparam logic [6:0] OFS_CS0  = 7'h40;
    localparam logic [6:0] OFS_CS1  = 7'h41;
    localparam logic [6:0] OFS_LAST = 7'h42;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int unsigned B_ON     = 15;
    localparam int unsigned B_SIZE   = 14;
    localparam int unsigned B_DIR    = 13;
    localparam int unsigned B_HALF   = 12;
    localparam int unsigned B_DUMMY_WRITE_EN  = 11;
    localparam int unsigned B_AM_LO  = 4;
    localparam int unsigned B_MD_LO  = 0;
    localparam int unsigned B_FORCE  = 15;
    localparam logic [15:0] CTL_MASK = 16'hf833;
    // ----------------------------------------------------------------
    // reset values and encodings
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [3:0]  RST_LAST  = 4'hf;
    localparam logic [1:0]  AM_INC    = 2'h0;
    localparam logic [1:0]  AM_PERIPH = 2'h2;
    localparam logic [1:0]  AM_RSVD   = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_FETCH = 2'b10,
        ST_WRITE = 2'b11
    } xfer_state_t;
endpackage

//--- rtl/chan_track.sv
// per-channel block tracker: pending request, block position, buffer toggle
`timescale 1ns/1ps
module chan_track
(
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        enable,
    input  wire logic [1:0]  mode,
    input  wire logic [1:0]  addressing_sel,
    input  wire logic        byte_sel,
    input  wire logic        half_sel,
    input  wire logic [15:0] sta,
    input  wire logic [15:0] stb,
    input  wire logic [9:0]  cnt,
    input  wire logic [15:0] periph_offset,
    input  wire logic        trig,
    input  wire logic        grant,
    output logic             pending,
    output logic             toggle,
    output logic [15:0]      ram_addr,
    output logic             irq_evt,
    output logic             stop_evt
);
    logic [9:0]  idx_reg;
    logic        pend_reg;
    logic        tog_reg;
    logic        last;
    logic [15:0] base;
    logic [15:0] step;

    assign last     = (idx_reg == cnt);
    assign base     = tog_reg ? stb : sta;
    assign pending  = pend_reg;
    assign toggle   = tog_reg;
    // post-increment steps by one byte or one word; no increment and reserved stay put
    assign step     = byte_sel ? {6'h00, idx_reg} : {5'h00, idx_reg, 1'b0};
    always_comb
    begin
        unique case (addressing_sel)
            xfer_pkg::AM_INC:    ram_addr = base + step;
            xfer_pkg::AM_PERIPH: ram_addr = base + periph_offset;
            default:   ram_addr = base;            // reserved behaves as no increment
        endcase
    end
    // interrupt on half block or on block end
    assign irq_evt  = grant && (half_sel ? (idx_reg == (cnt >> 1)) : last);
    // one-shot stops after one block, or after both buffers in ping-pong
    assign stop_evt = grant && last && mode[0] && (!mode[1] || tog_reg);

    // ----------------------------------------------------------------
    // request latch: a new trigger wins over the grant of the old one
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!nrst || !enable)
            pend_reg <= 1'b0;
        else if (trig)
            pend_reg <= 1'b1;
        else if (grant)
            pend_reg <= 1'b0;
    end

    // block position restarts whenever the channel is off
    always_ff @(posedge clock)
    begin
        if (!nrst || !enable)
            idx_reg <= 10'h000;
        else if (grant)
            idx_reg <= last ? 10'h000 : idx_reg + 10'h001;
    end

    // ping-pong buffer toggle flips at each completed block
    always_ff @(posedge clock)
    begin
        if (!nrst)
            tog_reg <= 1'b0;
        else if (grant && last && mode[1])
            tog_reg <= !tog_reg;
    end
endmodule // chan_track

//--- sim/far_side_model.sv
// buffer memory and peripheral stand-in
`timescale 1ns/1ps
module far_side_model
(
    input  wire logic        clock,
    input  wire logic        ram_re,
    input  wire logic [15:0] ram_addr,
    input  wire logic        per_re,
    input  wire logic [15:0] per_addr,
    output logic [15:0]      ram_rdata = 16'h0000,
    output logic [15:0]      per_rdata = 16'h0000
);
    // data valid one cycle after a read, inverted after so stale data never matches
    always @(posedge clock)
    begin
        ram_rdata <= ram_re ? (ram_addr ^ 16'ha5a5) : ~ram_rdata;
        per_rdata <= per_re ? (per_addr ^ 16'h3c3c) : ~per_rdata;
    end
endmodule // far_side_model

//--- sim/xfer_sva.sv
// port checker of the transfer controller
`timescale 1ns/1ps
module xfer_sva
(
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic [6:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        ram_re,
    input wire logic        ram_we,
    input wire logic        per_re,
    input wire logic        per_we,
    input wire logic        per_byte,
    input wire logic [15:0] per_wdata,
    input wire logic [7:0]  irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // a read strobe is followed two cycles on by its write
    sequence s_fill; ##2 ram_we; endsequence
    sequence s_drain; ##2 per_we; endsequence
    a_fill_after_read: assert property (per_re |-> s_fill)
        else $error("no buffer write");
    a_drain_after_read: assert property (ram_re |-> s_drain)
        else $error("no peripheral write");
    a_read_spacing: assert property ((ram_re || per_re) |=> !(ram_re || per_re) [*3])
        else $error("transfers too close");
    a_null_write: assert property ((ram_we && per_we) |-> per_wdata == 16'h0000)
        else $error("dummy write not zero");
    a_byte_clean: assert property ((per_we && per_byte) |-> per_wdata[15:8] == 8'h00)
        else $error("byte write high byte set");
    a_irq_at_write: assert property ((irq != 8'h00) |-> (ram_we || per_we))
        else $error("irq without write");
    a_count_upper: assert property (reg_rd && reg_addr[2:0] == 3'h5 |=> reg_rdata[15:10] == 6'h00)
        else $error("count upper bits set");
    a_unmapped_zero: assert property (reg_rd && reg_addr > 7'h42 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
endmodule // xfer_sva
bind xfer_ctrl xfer_sva chk (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ram_re(ram_re), .ram_we(ram_we), .per_re(per_re), .per_we(per_we),
    .per_byte(per_byte), .per_wdata(per_wdata), .irq(irq));

//--- sim/testbench.sv
// self-checking bench of the transfer controller
`timescale 1ns/1ps
module testbench;
    logic         clock = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, cram_we = 1'b0, cper_we = 1'b0;
    logic [6:0]   reg_addr = 7'h00;
    logic [15:0]  reg_wdata = 16'h0000, cram_a = 16'h0000, cper_a = 16'h0000, poff = 16'h0000, reg_rdata, ram_rdata;
    logic [15:0]  per_rdata, ram_addr, ram_wdata, per_addr, per_wdata, wv [64];
    logic         ram_re, ram_we, ram_byte, per_re, per_we, per_byte;
    logic [127:0] trig = '0;
    logic [7:0]   irq;
    logic [31:0]  exp_ram [$], exp_per [$];
    logic [15:0]  msk [8] = '{16'h7833, 16'h007f, 16'hffff, 16'hffff, 16'hffff, 16'h03ff, 16'h0, 16'h0};
    int           errors = 0, n_tests = 0, irq_sum = 0, exp_byte = 0;
    xfer_ctrl dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trigger_source_line(trig), .periph_offset(poff),
        .ram_rdata(ram_rdata), .per_rdata(per_rdata), .cpu_ram_we(cram_we), .cpu_ram_addr(cram_a),
        .cpu_per_we(cper_we), .cpu_per_addr(cper_a), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
        .ram_re(ram_re), .ram_we(ram_we), .ram_byte(ram_byte), .per_addr(per_addr), .per_wdata(per_wdata),
        .per_re(per_re), .per_we(per_we), .per_byte(per_byte), .irq(irq));
    far_side_model far (.clock(clock), .ram_re(ram_re), .ram_addr(ram_addr), .per_re(per_re),
        .per_addr(per_addr), .ram_rdata(ram_rdata), .per_rdata(per_rdata));
    // 100 MHz clock
    initial
    begin
        forever #5 clock = ~clock;
    end
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // read data appears in the cycle after the strobe and holds until the next read
    task automatic rd_chk(input logic [6:0] a, input logic [15:0] e);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 check_val({16'h0, reg_rdata}, {16'h0, e});
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // engine writes against the expected queues
    always @(posedge clock)
    begin
        if (ram_we === 1'b1)
            check_val({ram_addr, ram_wdata}, exp_ram.size() ? exp_ram.pop_front() : 32'hx);
        if (per_we === 1'b1)
            check_val({per_addr, per_wdata}, exp_per.size() ? exp_per.pop_front() : 32'hx);
        if (per_we === 1'b1)
            check_val({30'h0, ram_byte, per_byte}, exp_byte ? 32'h3 : 32'h0);
        // weighted sum also tells which channel raised the pulse
        if (irq !== 8'h00)
            irq_sum += int'(irq);
    end
    // watchdog sized well above the expected run
    initial
    begin
        repeat (5000) @(posedge clock);
        errors++;
        wrap_up();
    end
    initial
    begin
        void'($urandom(10));
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        for (int i = 0; i < 64; i++)
            rd_chk(7'(i), 16'h0000);
        rd_chk(7'h41, 16'h0f00);
        rd_chk(7'h42, 16'h0000);
        rd_chk(7'h7f, 16'h0000);
        $display("reset values done");
        for (int i = 0; i < 64; i++)
        begin
            wv[i] = 16'($urandom) & ((i % 8 < 2) ? 16'h7fff : 16'hffff);
            wr(7'(i), wv[i]);
        end
        for (int i = 0; i < 64; i++)
            rd_chk(7'(i), wv[i] & msk[i % 8]);
        @(posedge clock);
        nrst <= 1'b0;
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        $display("register access done");
        wr(7'h12, 16'h0100);
        wr(7'h14, 16'h0210);
        wr(7'h15, 16'h0002);
        wr(7'h11, 16'h0025);
        cram_a <= 16'h0100;
        cper_a <= 16'h0210;
        cram_we <= 1'b1;
        cper_we <= 1'b1;
        wr(7'h10, 16'h8800);
        for (int i = 0; i < 3; i++)
        begin
            exp_ram.push_back({16'h0100 + 16'(2 * i), 16'h3e2c});
            exp_per.push_back({16'h0210, 16'h0000});
            trig[37] <= 1'b1;
            @(posedge clock);
            trig[37] <= 1'b0;
            repeat (9) @(posedge clock);
        end
        cram_we <= 1'b0;
        cper_we <= 1'b0;
        check_val(32'(irq_sum), 32'd4);
        rd_chk(7'h40, 16'h0404);
        wr(7'h40, 16'h0404);
        rd_chk(7'h40, 16'h0000);
        rd_chk(7'h41, 16'h0200);
        rd_chk(7'h42, 16'h0104);
        wr(7'h10, 16'h0000);
        $display("request transfers done");
        wr(7'h2a, 16'h0300);
        wr(7'h2c, 16'h0450);
        wr(7'h28, 16'he011);
        exp_byte = 1;
        exp_per.push_back({16'h0450, 16'h00a5});
        wr(7'h29, 16'h8000);
        repeat (10) @(posedge clock);
        check_val(32'(exp_ram.size() + exp_per.size()), 32'd0);
        check_val(32'(irq_sum), 32'd36);
        rd_chk(7'h29, 16'h0000);
        rd_chk(7'h28, 16'h6011);
        rd_chk(7'h41, 16'h0500);
        rd_chk(7'h42, 16'h0300);
        $display("forced transfer done");
        wr(7'h3a, 16'h0200);
        poff <= 16'h0010;
        wr(7'h3b, 16'h0300);
        wr(7'h3c, 16'h0460);
        wr(7'h3d, 16'h0001);
        wr(7'h39, 16'h0001);
        exp_byte = 0;
        wr(7'h38, 16'hb023);
        for (int j = 0; j < 2; j++)
        begin
            for (int i = 0; i < 2; i++)
            begin
                exp_per.push_back({16'h0460, (j ? 16'h0310 : 16'h0210) ^ 16'ha5a5});
                @(posedge clock);
                trig[1] <= 1'b1;
                @(posedge clock);
                trig[1] <= 1'b0;
                repeat (8) @(posedge clock);
            end
            rd_chk(7'h41, j ? 16'h0700 : 16'h0780);
        end
        check_val(32'(exp_ram.size() + exp_per.size()), 32'd0);
        check_val(32'(irq_sum), 32'd292);
        rd_chk(7'h38, 16'h3023);
        rd_chk(7'h42, 16'h0310);
        $display("ping-pong transfers done");
        wrap_up();
    end
endmodule // testbench
